// *** design/crfb_top.v ***
// Configuration readback frame builder with AXI4-Lite register access
// Summary of operation
// - The channel 5 to 8 frame carries identifier 0x18FF11 then the node address, priority 6, PF 255, PS 17.
// - The following frame carries identifier 0x18FF12 then the node address, priority 6, PF 255, PS 18.
// - Frames go out only on request, and none enters the output buffer later than 100 ms after the request; buffered frames may leave later.
// - The top bit of each channel's first byte is its fast-disconnect status.
// - The three bits below it in the first byte hold the basic ON-delay code.
// - The low four bits of the first byte hold the ON-delay multiplier.
// - The second byte's top bit carries nothing and the next three hold the basic OFF-delay code.
// - The low four bits of the second byte hold the OFF-delay multiplier.
// - The channel 5 to 8 frame copies stored bytes 0x68 to 0x6F in ascending order into payload bytes 1 to 8.
// - The frame before it carries channels 1 to 4 from stored bytes 0x60 to 0x67 in the same layout.
// - The PS 18 frame copies stored bytes 0x70 to 0x77 in ascending order into payload bytes 1 to 8.
// - A query whose third byte is 0x02 is answered with four consecutive readback frames.
`timescale 1ns/1ps
`include "crfb_defs.vh"
module crfb_top #(
  parameter RESP_LIMIT_CYC = `CRFB_RESP_LIMIT_MS * `CRFB_CLK_KHZ
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire        s_axil_awvalid,
  output reg         s_axil_awready,
  input  wire [7:0]  s_axil_awaddr,
  input  wire [2:0]  s_axil_awprot,
  // AXI4-Lite write data
  input  wire        s_axil_wvalid,
  output reg         s_axil_wready,
  input  wire [31:0] s_axil_wdata,
  input  wire [3:0]  s_axil_wstrb,
  // AXI4-Lite write response
  output reg         s_axil_bvalid,
  input  wire        s_axil_bready,
  output reg  [1:0]  s_axil_bresp,
  // AXI4-Lite read address
  input  wire        s_axil_arvalid,
  output reg         s_axil_arready,
  input  wire [7:0]  s_axil_araddr,
  input  wire [2:0]  s_axil_arprot,
  // AXI4-Lite read data
  output reg         s_axil_rvalid,
  input  wire        s_axil_rready,
  output reg  [31:0] s_axil_rdata,
  output reg  [1:0]  s_axil_rresp,
  // Received query frames
  input  wire        query_valid,
  output reg         query_ready,
  input  wire [28:0] query_id,
  input  wire [63:0] query_data,
  // Readback frames towards the CAN controller
  output wire        frame_valid,
  input  wire        frame_ready,
  output wire [28:0] frame_id,
  output wire [63:0] frame_data
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  // The limit counts clock cycles; a zero setting would wrap the compare
  // and never abort, so one cycle is the floor
  localparam [31:0] LIMIT_CYC = (RESP_LIMIT_CYC < 1) ? 32'd1 : RESP_LIMIT_CYC;

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [31:0] cfg_mem [0:7];
  reg [31:0] ctrl_reg;
  reg        late_reg;
  reg        drop_reg;
  reg        state_reg;
  reg [2:0]  frame_idx_reg;
  reg [31:0] timer_reg;

  reg        aw_held_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  wire       enable    = ctrl_reg[`CRFB_CTRL_EN_BIT];
  wire [7:0] node_addr = ctrl_reg[`CRFB_CTRL_NODE_LSB +: 8];
  wire       busy      = (state_reg == ST_SEND);

  // Late and drop stay set until software writes a one back
  wire [31:0] status_word = {29'h0, drop_reg, late_reg, busy};

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  wire       do_write  = aw_held_reg && w_held_reg && !s_axil_bvalid;
  wire       wr_cfg    = (aw_addr_reg[7:5] == 3'h3) && (aw_addr_reg[1:0] == 2'h0);
  wire       wr_ctrl   = (aw_addr_reg == `CRFB_OFS_CTRL);
  wire       wr_status = (aw_addr_reg == `CRFB_OFS_STATUS);
  wire       wr_hit    = wr_cfg || wr_ctrl || wr_status;
  wire [2:0] wr_word   = aw_addr_reg[4:2];

  integer k;
  integer j;

  // Address and data are taken in either order and held until both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= 2'h0;
      aw_held_reg    <= 1'b0;
      aw_addr_reg    <= 8'h00;
      w_held_reg     <= 1'b0;
      w_data_reg     <= 32'h0000_0000;
      w_strb_reg     <= 4'h0;
      ctrl_reg       <= `CRFB_CTRL_RESET;
      for (k = 0; k < 8; k = k + 1) begin
        cfg_mem[k] <= 32'h0000_0000;
      end
    end else begin
      s_axil_awready <= !aw_held_reg && !(s_axil_awvalid && s_axil_awready);
      s_axil_wready  <= !w_held_reg && !(s_axil_wvalid && s_axil_wready);
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axil_wdata;
        w_strb_reg <= s_axil_wstrb;
      end
      if (do_write) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= wr_hit ? 2'h0 : 2'h2;
        for (j = 0; j < 4; j = j + 1) begin
          if (w_strb_reg[j]) begin
            if (wr_cfg) begin
              cfg_mem[wr_word][8*j +: 8] <= w_data_reg[8*j +: 8];
            end
            if (wr_ctrl) begin
              ctrl_reg[8*j +: 8] <= w_data_reg[8*j +: 8];
            end
          end
        end
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid  <= 1'b0;
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  wire       rd_cfg  = (s_axil_araddr[7:5] == 3'h3) && (s_axil_araddr[1:0] == 2'h0);
  wire [2:0] rd_word = s_axil_araddr[4:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h0000_0000;
      s_axil_rresp   <= 2'h0;
    end else begin
      s_axil_arready <= !s_axil_rvalid && !(s_axil_arvalid && s_axil_arready);
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rresp  <= 2'h0;
        if (rd_cfg) begin
          s_axil_rdata <= cfg_mem[rd_word];
        end else if (s_axil_araddr == `CRFB_OFS_CTRL) begin
          s_axil_rdata <= ctrl_reg;
        end else if (s_axil_araddr == `CRFB_OFS_STATUS) begin
          s_axil_rdata <= status_word;
        end else begin
          s_axil_rdata <= 32'h0000_0000;
          s_axil_rresp <= 2'h2;
        end
      end
      if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid  <= 1'b0;
        s_axil_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Query decode
  // ****************************************************************
  wire q_take = query_valid && query_ready;
  // Priority, page and sender are not checked, so any requester may ask
  // Identifier bits: priority and page above PF, then destination, then sender
  wire q_match = (query_id[23:16] == `CRFB_PF_QUERY) &&
                 (query_id[15:8] == node_addr) &&
                 (query_data[47:40] == `CRFB_QUERY_CMD);

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  wire        buf_in_ready;
  wire [63:0] raw_bytes;
  wire [28:0] pack_id;
  wire [63:0] pack_data;
  wire        push = busy && buf_in_ready;
  wire        last_frame = (frame_idx_reg == `CRFB_FRAME_COUNT - 3'h1);
  wire        timed_out = busy && (timer_reg >= LIMIT_CYC - 32'd1);

  // ****************************************************************
  // Stored word selection
  // ****************************************************************
  // Frame n reads stored words 2n and 2n+1
  wire [2:0]  word_lo_idx = {frame_idx_reg[1:0], 1'b0};
  wire [2:0]  word_hi_idx = {frame_idx_reg[1:0], 1'b1};
  wire [31:0] word_lo     = cfg_mem[word_lo_idx];
  wire [31:0] word_hi     = cfg_mem[word_hi_idx];

  // Lane 0 holds the lowest address, which goes out as payload byte 1
  assign raw_bytes = {word_lo[7:0],   word_lo[15:8],
                      word_lo[23:16], word_lo[31:24],
                      word_hi[7:0],   word_hi[15:8],
                      word_hi[23:16], word_hi[31:24]};

  crfb_pack u_pack (
    .pdu_specific (`CRFB_PS_FIRST + {5'h0, frame_idx_reg}),
    .node_addr    (node_addr),
    .chan_frame   (frame_idx_reg < `CRFB_CHAN_FRAMES),
    .raw_bytes    (raw_bytes),
    .frame_id     (pack_id),
    .frame_data   (pack_data)
  );

  // A frame not handed over within the limit is dropped, never sent late
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_IDLE;
      frame_idx_reg <= 3'h0;
      timer_reg     <= 32'h0000_0000;
      late_reg      <= 1'b0;
      drop_reg      <= 1'b0;
      query_ready   <= 1'b0;
    end else begin
      query_ready <= 1'b1;
      // Software clears with a one; a new event in the same cycle still wins
      if (do_write && wr_status && w_strb_reg[0]) begin
        if (w_data_reg[`CRFB_ST_LATE_BIT]) begin
          late_reg <= 1'b0;
        end
        if (w_data_reg[`CRFB_ST_DROP_BIT]) begin
          drop_reg <= 1'b0;
        end
      end
      case (state_reg)
        ST_IDLE: begin
          if (q_take && q_match && enable) begin
            state_reg     <= ST_SEND;
            frame_idx_reg <= 3'h0;
            timer_reg     <= 32'h0000_0000;
          end
        end
        ST_SEND: begin
          timer_reg <= timer_reg + 32'd1;
          // A query during an answer is not queued; the flag tells software it was lost
          if (q_take && q_match) begin
            drop_reg <= 1'b1;
          end
          if (push && !timed_out) begin
            frame_idx_reg <= frame_idx_reg + 3'h1;
            if (last_frame) begin
              state_reg <= ST_IDLE;
            end
          end else if (timed_out) begin
            late_reg  <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  // Holding two frames lets a one-cycle stall pass; a frame taken during it drops upstream ready for the next cycle
  crfb_skid #(
    .WIDTH (93)
  ) u_skid (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push && !timed_out),
    .in_ready  (buf_in_ready),
    .in_data   ({pack_id, pack_data}),
    .out_valid (frame_valid),
    .out_ready (frame_ready),
    .out_data  ({frame_id, frame_data})
  );

endmodule

// *** design/crfb_defs.vh ***
// Constants for the configuration readback frame builder
`ifndef CRFB_DEFS_VH
`define CRFB_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CRFB_OFS_CTRL      8'h00
`define CRFB_OFS_STATUS    8'h04
`define CRFB_OFS_CFG_BASE  8'h60
`define CRFB_OFS_CFG_LAST  8'h7c

// ****************************************************************
// Control and status fields
// ****************************************************************
`define CRFB_CTRL_EN_BIT    0
`define CRFB_CTRL_NODE_LSB  8
`define CRFB_ST_BUSY_BIT    0
`define CRFB_ST_LATE_BIT    1
`define CRFB_ST_DROP_BIT    2
`define CRFB_CTRL_RESET     32'h0000_a001

// ****************************************************************
// Frame identifiers and query layout
// ****************************************************************
`define CRFB_PRIO           3'h6
`define CRFB_PF_READBACK    8'hff
`define CRFB_PS_FIRST       8'h10
`define CRFB_PF_QUERY       8'hef
`define CRFB_QUERY_CMD      8'h02
`define CRFB_FRAME_COUNT    3'h4
`define CRFB_CHAN_FRAMES    3'h3

// ****************************************************************
// Channel byte pair fields
// ****************************************************************
`define CRFB_FAST_BIT       7
`define CRFB_BASIC_MSB      6
`define CRFB_BASIC_LSB      4
`define CRFB_MULT_MSB       3
`define CRFB_MULT_LSB       0

// ****************************************************************
// Timing
// ****************************************************************
`define CRFB_RESP_LIMIT_MS  100
`define CRFB_CLK_KHZ        200000

`endif

// *** design/crfb_skid.v ***
// Two-entry buffer with registered valid and ready on both sides
`timescale 1ns/1ps
module crfb_skid #(
  parameter WIDTH = 93
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Fill side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg             skid_valid_reg;
  reg [WIDTH-1:0] skid_data_reg;

  wire take = in_valid && in_ready;
  wire give = out_valid && out_ready;

  // Second entry catches the word that arrives while the drain stalls
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid      <= 1'b0;
      out_data       <= {WIDTH{1'b0}};
      skid_valid_reg <= 1'b0;
      skid_data_reg  <= {WIDTH{1'b0}};
      in_ready       <= 1'b0;
    end else begin
      in_ready <= 1'b1;
      if (give || !out_valid) begin
        if (skid_valid_reg) begin
          out_data       <= skid_data_reg;
          out_valid      <= 1'b1;
          skid_valid_reg <= take;
          skid_data_reg  <= in_data;
        end else begin
          out_valid <= take;
          out_data  <= in_data;
        end
      end else if (take) begin
        skid_valid_reg <= 1'b1;
        skid_data_reg  <= in_data;
        in_ready       <= 1'b0;
      end else if (skid_valid_reg) begin
        in_ready <= 1'b0;
      end
    end
  end

endmodule

// *** design/crfb_pack.v ***
// Builds one readback frame identifier and payload from eight stored bytes
`timescale 1ns/1ps
`include "crfb_defs.vh"
module crfb_pack (
  // Frame selection
  input  wire [7:0]  pdu_specific,
  input  wire [7:0]  node_addr,
  input  wire        chan_frame,
  // Stored bytes, first byte in the top lane
  input  wire [63:0] raw_bytes,
  // Formatted frame
  output wire [28:0] frame_id,
  output reg  [63:0] frame_data
);

  integer i;

  // Priority, reserved, data page, PDU format, PDU specific, source
  assign frame_id = {`CRFB_PRIO, 1'b0, 1'b0, `CRFB_PF_READBACK, pdu_specific, node_addr};

  // Fast flag, basic and multiplier fields pass in place; only the spare top bit
  // of each second channel byte is forced low
  always @* begin
    frame_data = raw_bytes;
    for (i = 0; i < 4; i = i + 1) begin
      if (chan_frame) begin
        frame_data[16*i+`CRFB_FAST_BIT] = 1'b0;
      end
    end
  end

endmodule

// *** test/crfb_chk.sv ***
// Port assertions for the readback frame builder
`timescale 1ns/1ps
module crfb_chk #(
  parameter RESP_LIMIT_CYC = 20
) (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_axil_awvalid,
  input wire        s_axil_awready,
  input wire        s_axil_wvalid,
  input wire        s_axil_wready,
  input wire        s_axil_bvalid,
  input wire        s_axil_bready,
  input wire        s_axil_arvalid,
  input wire        s_axil_arready,
  input wire        s_axil_rvalid,
  input wire        s_axil_rready,
  input wire [31:0] s_axil_rdata,
  input wire [1:0]  s_axil_rresp,
  // Query stream
  input wire        query_ready,
  // Frame stream
  input wire        frame_valid,
  input wire        frame_ready,
  input wire [28:0] frame_id,
  input wire [63:0] frame_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence wr_take_s;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence fr_take_s;
    frame_valid && frame_ready && frame_id[15:8] < 8'h13;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  frame_hold_a: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_id) && $stable(frame_data))
    else $error("frame changed while stalled");
  frame_base_a: assert property (frame_valid |-> frame_id[28:16] == 13'h18ff)
    else $error("frame priority or format wrong");
  frame_ps_a: assert property (frame_valid |-> frame_id[15:10] == 6'h04)
    else $error("frame group out of range");
  frame_order_a: assert property (fr_take_s ##1 frame_valid |-> frame_id[15:8] == $past(frame_id[15:8]) + 8'h1 || frame_id[15:8] == 8'h10)
    else $error("frames out of order");
  spare_zero_a: assert property (frame_valid && frame_id[15:8] != 8'h13 |-> !(frame_data[55] | frame_data[39] | frame_data[23] | frame_data[7]))
    else $error("spare bit set");
  wr_lat_a: assert property (wr_take_s |=> !s_axil_bvalid ##1 s_axil_bvalid)
    else $error("write answer late");
  rd_lat_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer late");
  b_done_a: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
    else $error("write answer repeated");
  r_done_a: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
    else $error("read answer repeated");
  unmapped_zero_a: assert property (s_axil_rvalid && s_axil_rresp == 2'h2 |-> s_axil_rdata == 32'h0)
    else $error("error read with data");
  query_open_a: assert property ($past(aresetn) |-> query_ready)
    else $error("query input closed");
endmodule
bind crfb_top crfb_chk #(.RESP_LIMIT_CYC(RESP_LIMIT_CYC)) u_crfb_chk (
  .aclk (aclk), .aresetn (aresetn),
  .s_axil_awvalid (s_axil_awvalid), .s_axil_awready (s_axil_awready),
  .s_axil_wvalid (s_axil_wvalid), .s_axil_wready (s_axil_wready),
  .s_axil_bvalid (s_axil_bvalid), .s_axil_bready (s_axil_bready),
  .s_axil_arvalid (s_axil_arvalid), .s_axil_arready (s_axil_arready),
  .s_axil_rvalid (s_axil_rvalid), .s_axil_rready (s_axil_rready),
  .s_axil_rdata (s_axil_rdata), .s_axil_rresp (s_axil_rresp),
  .query_ready (query_ready),
  .frame_valid (frame_valid), .frame_ready (frame_ready),
  .frame_id (frame_id), .frame_data (frame_data)
);

// *** test/crfb_peer.sv ***
// Remote node model: issues queries, takes frames with random stalls
`timescale 1ns/1ps
module crfb_peer (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Bench control
  input  wire         go,
  input  wire         hold,
  input  wire  [28:0] q_id,
  input  wire  [63:0] q_dat,
  // Query stream
  output logic        query_valid,
  input  wire         query_ready,
  output logic [28:0] query_id,
  output logic [63:0] query_data,
  // Frame stream
  output logic        frame_ready
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      query_valid <= 1'b0;
      query_id <= 29'h0;
      query_data <= 64'h0;
      frame_ready <= 1'b0;
    end else begin
      frame_ready <= !hold && ($urandom % 4 != 0);
      if (go) begin
        query_valid <= 1'b1;
        query_id <= q_id;
        query_data <= q_dat;
      end else if (query_valid && query_ready) begin
        // Released bus shows the inverse so stale content never passes
        query_valid <= 1'b0;
        query_id <= ~query_id;
        query_data <= ~query_data;
      end
    end
  end
endmodule

// *** test/config_readback_frame_builder_tb_top.sv ***
// Bench for the readback frame builder: model, scenarios and verdict
`timescale 1ns/1ps
module config_readback_frame_builder_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam LIMIT = 40;
  localparam logic [15:0] MFR_TAG = 16'h5a3c; // Arbitrary maker bytes; the design does not check them
  logic aclk = 0, aresetn = 0, go = 0, hold = 0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0, s_axil_arvalid = 0, s_axil_rready = 0;
  logic [7:0]  s_axil_awaddr = 0, s_axil_araddr = 0;
  logic [2:0]  s_axil_awprot = 0, s_axil_arprot = 0;
  logic [31:0] s_axil_wdata = 0;
  logic [3:0]  s_axil_wstrb = 4'hf;
  logic [28:0] q_id = 0;
  logic [63:0] q_dat = 0;
  wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  wire query_valid, query_ready, frame_valid, frame_ready;
  wire [1:0]  s_axil_bresp, s_axil_rresp;
  wire [31:0] s_axil_rdata;
  wire [28:0] query_id, frame_id;
  wire [63:0] query_data, frame_data;
  logic [7:0]  cfg [0:31];
  logic [28:0] eid [$];
  logic [63:0] edat [$];
  int failures = 0, comparisons = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  // Short response limit so a stalled receiver trips the abort
  crfb_top #(.RESP_LIMIT_CYC(LIMIT)) u_crfb_top (
    .aclk (aclk), .aresetn (aresetn),
    .s_axil_awvalid (s_axil_awvalid), .s_axil_awready (s_axil_awready), .s_axil_awaddr (s_axil_awaddr),
    .s_axil_awprot (s_axil_awprot), .s_axil_wvalid (s_axil_wvalid), .s_axil_wready (s_axil_wready),
    .s_axil_wdata (s_axil_wdata), .s_axil_wstrb (s_axil_wstrb), .s_axil_bvalid (s_axil_bvalid),
    .s_axil_bready (s_axil_bready), .s_axil_bresp (s_axil_bresp), .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready), .s_axil_araddr (s_axil_araddr), .s_axil_arprot (s_axil_arprot),
    .s_axil_rvalid (s_axil_rvalid), .s_axil_rready (s_axil_rready), .s_axil_rdata (s_axil_rdata),
    .s_axil_rresp (s_axil_rresp), .query_valid (query_valid), .query_ready (query_ready),
    .query_id (query_id), .query_data (query_data), .frame_valid (frame_valid),
    .frame_ready (frame_ready), .frame_id (frame_id), .frame_data (frame_data)
  );
  crfb_peer u_crfb_peer (
    .aclk (aclk), .aresetn (aresetn), .go (go), .hold (hold), .q_id (q_id), .q_dat (q_dat),
    .query_valid (query_valid), .query_ready (query_ready), .query_id (query_id),
    .query_data (query_data), .frame_ready (frame_ready)
  );
  // ****************************************************************
  // Compare and report
  // ****************************************************************
  task cmp_word(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_frame(input logic [92:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  // ****************************************************************
  // Bus tasks and model
  // ****************************************************************
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axil_awvalid <= 1;
    s_axil_wvalid <= 1;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 0;
      if (s_axil_wready) s_axil_wvalid <= 0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 0;
    cmp_word({30'h0, s_axil_bresp}, {30'h0, er});
  endtask
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axil_arvalid <= 1;
    s_axil_araddr <= a;
    s_axil_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 0;
    end while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 0;
    cmp_word(s_axil_rdata, e);
    cmp_word({30'h0, s_axil_rresp}, {30'h0, er});
  endtask
  task expect_answer(input logic [7:0] node);
    logic [63:0] d;
    for (int n = 0; n < 4; n++) begin
      // Last frame carries ratings, so its top bits are not masked
      for (int b = 0; b < 8; b++) d[63-8*b -: 8] = cfg[8*n+b] & ((n < 3 && b[0]) ? 8'h7f : 8'hff);
      eid.push_back({3'h6, 2'h0, 8'hff, 8'h10 + n[7:0], node});
      edat.push_back(d);
    end
  endtask
  task query(input logic [7:0] node, cmd, input int n);
    @(posedge aclk);
    go <= 1;
    q_id <= {3'h6, 2'h0, 8'hef, node, 8'h64};
    q_dat <= {MFR_TAG, cmd, 40'h0};
    repeat (n) @(posedge aclk);
    go <= 0;
  endtask
  task settle;
    for (int i = 0; i < 200 && eid.size() > 0; i++) @(posedge aclk);
    repeat (10) @(posedge aclk);
    cmp_word(32'(eid.size()), 32'h0);
  endtask
  always @(posedge aclk) begin
    if (aresetn && frame_valid && frame_ready)
      cmp_frame({frame_id, frame_data}, eid.size() ? {eid.pop_front(), edat.pop_front()} : 93'hx);
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [31:0] d;
    void'($urandom(32'hbba412a7));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    axr(8'h00, 32'h0000a001, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axr(8'h60, 32'h0, 2'h0);
    for (int w = 0; w < 8; w++) begin
      d = $urandom;
      {cfg[4*w+3], cfg[4*w+2], cfg[4*w+1], cfg[4*w]} = d;
      axw(8'h60 + 8'(4 * w), d, 2'h0);
    end
    axr(8'h6c, {cfg[15], cfg[14], cfg[13], cfg[12]}, 2'h0);
    axr(8'h40, 32'h0, 2'h2);
    axw(8'h40, 32'h1, 2'h2);
    expect_answer(8'ha0);
    query(8'ha0, 8'h02, 1);
    settle;
    query(8'ha0, 8'h03, 1);
    query(8'h5b, 8'h02, 1);
    settle;
    expect_answer(8'ha0);
    query(8'ha0, 8'h02, 2);
    settle;
    axr(8'h04, 32'h4, 2'h0);
    axw(8'h04, 32'h4, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axw(8'h00, 32'h00005b00, 2'h0);
    query(8'h5b, 8'h02, 1);
    settle;
    axw(8'h00, 32'h00005b01, 2'h0);
    expect_answer(8'h5b);
    query(8'h5b, 8'h02, 1);
    settle;
    hold <= 1;
    expect_answer(8'h5b);
    query(8'h5b, 8'h02, 1);
    repeat (3 * LIMIT) @(posedge aclk);
    hold <= 0;
    repeat (20) @(posedge aclk);
    eid.delete();
    edat.delete();
    axr(8'h04, 32'h2, 2'h0);
    // Only lane 0 is enabled, so the node address must survive
    s_axil_wstrb <= 4'h1;
    axw(8'h00, 32'hffff_ff00, 2'h0);
    s_axil_wstrb <= 4'hf;
    axr(8'h00, 32'h00005b00, 2'h0);
    report_and_stop;
  end
endmodule
